// ===== rtl/mame_exec.sv
// move and multiply execution slice of an 8-bit core, four phases a cycle
// Operation
// [RULE1] bank high load writes the 4-bit literal into the upper bank nibble
// [RULE2] bank high load keeps the lower bank nibble unchanged
// [RULE3] bank high load pattern 1011 101x kkkk uuuu, literal in bits 7..4
// [RULE4] 1011 0000 kkkkkkkk loads the literal into working register, no flags
// [RULE5] prefix 010 p f copies location p into f, updates the zero flag
// [RULE6] move destination spans 00h..FFh, source spans 00h..1Fh only
// [RULE7] either move operand may be the working register location
// [RULE8] both move operands may resolve through the indirect pointers
// [RULE9] 0000 0001 f writes the working register to any location, no flags
// [RULE10] 1011 1100 k multiplies literal by working register, register kept
// [RULE11] 0011 0100 f multiplies working register by the addressed location
// [RULE12] both multiplies store the 16-bit product, high and low bytes
// [RULE13] file multiply leaves working register and location unmodified
// [RULE14] multiplies change no status flag, zero product not flagged
// [RULE15] each instruction: decode, read, process, write in final phase
`timescale 1ns/10ps
module mame_exec (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   input wire logic [7:0] pointer0,
   input wire logic [7:0] pointer1,
   input wire logic [7:0] rd_data,
   output logic decode_phase,
   output logic [7:0] rd_addr,
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data,
   output logic [7:0] working_register,
   output logic [7:0] bank_selection_register,
   output logic [7:0] product_high,
   output logic [7:0] product_low,
   output logic zero_flag
);
   typedef struct packed {
      mame_pkg::mame_phase_e phase;
      mame_pkg::mame_op_e op;
      logic [7:0] lit;
      logic [7:0] src;
      logic [7:0] dst;
      logic [7:0] opnd;
      logic decode_phase;
      logic [7:0] rd_addr;
      logic wr_en;
      logic [7:0] wr_addr;
      logic [7:0] wr_data;
      logic [7:0] work_reg;
      logic [7:0] bank_sel;
      logic [7:0] prod_high;
      logic [7:0] prod_low;
      logic zero;
   } mame_exec_s;

   localparam mame_exec_s RST_S = '{
      phase: mame_pkg::PH_DECODE,
      op: mame_pkg::OP_NONE,
      lit: 8'h00,
      src: 8'h00,
      dst: 8'h00,
      opnd: 8'h00,
      decode_phase: 1'b1,
      rd_addr: 8'h00,
      wr_en: 1'b0,
      wr_addr: 8'h00,
      wr_data: 8'h00,
      work_reg: mame_pkg::WORK_REG_RST,
      bank_sel: mame_pkg::BANK_SEL_RST,
      prod_high: mame_pkg::PROD_RST[15:8],
      prod_low: mame_pkg::PROD_RST[7:0],
      zero: 1'b0
   };

   mame_exec_s s;
   mame_exec_s next_s;
   mame_mul_if mul ();

   mame_mul u_mul (
      .core_clk(core_clk),
      .rstn(rstn),
      .mul(mul.requester)
   );

   // an operand naming an indirect location is replaced by its pointer
   function automatic logic [7:0] resolve(input logic [7:0] addr,
                                          input logic [7:0] p0,
                                          input logic [7:0] p1);
      logic [7:0] r;
      r = addr;
      if (addr == mame_pkg::IND0_ADDR) begin
         r = p0; // RULE8
      end else if (addr == mame_pkg::IND1_ADDR) begin
         r = p1; // RULE8
      end
      return r;
   endfunction : resolve

   function automatic mame_pkg::mame_op_e decode(input logic [15:0] w);
      mame_pkg::mame_op_e o;
      o = mame_pkg::OP_NONE;
      if (w[15:mame_pkg::OP7_LSB] == mame_pkg::BANK_HIGH_OP) begin
         o = mame_pkg::OP_BANK_HIGH_LOAD; // RULE3
      end else if (w[15:mame_pkg::OP8_LSB] == mame_pkg::LIT_TO_W_OP) begin
         o = mame_pkg::OP_LITERAL_TO_WORKING; // RULE4
      end else if (w[15:mame_pkg::OP3_LSB] == mame_pkg::P_TO_F_OP) begin
         o = mame_pkg::OP_PERIPHERAL_TO_FILE; // RULE5
      end else if (w[15:mame_pkg::OP8_LSB] == mame_pkg::W_TO_F_OP) begin
         o = mame_pkg::OP_WORKING_TO_FILE; // RULE9
      end else if (w[15:mame_pkg::OP8_LSB] == mame_pkg::LIT_MUL_OP) begin
         o = mame_pkg::OP_LITERAL_MULTIPLY; // RULE10
      end else if (w[15:mame_pkg::OP8_LSB] == mame_pkg::FILE_MUL_OP) begin
         o = mame_pkg::OP_FILE_MULTIPLY; // RULE11
      end
      return o;
   endfunction : decode

   // multiplier is fed in the process phase and captures at its end
   always_comb begin
      mul.go = (s.phase == mame_pkg::PH_PROCESS) &&
               ((s.op == mame_pkg::OP_LITERAL_MULTIPLY) ||
                (s.op == mame_pkg::OP_FILE_MULTIPLY));
      mul.a = s.work_reg;
      mul.b = (s.op == mame_pkg::OP_LITERAL_MULTIPLY) ? s.lit : s.opnd;
   end

   always_comb begin
      logic [4:0] p_field;
      logic [7:0] f_res;
      logic [7:0] p_res;
      logic wr_int;
      next_s = s;
      p_field = instr[mame_pkg::P_LSB +: mame_pkg::PERIPH_W];
      f_res = resolve(instr[7:0], pointer0, pointer1);
      // source is zero-extended from 5 bits; 00h and 08h then resolve to a pointer of any value
      p_res = resolve({3'h0, p_field}, pointer0, pointer1); // RULE6
      wr_int = (s.dst == mame_pkg::WORK_REG_ADDR);
      next_s.decode_phase = 1'b0;
      next_s.wr_en = 1'b0;
      case (s.phase)
         mame_pkg::PH_DECODE: begin
            next_s.phase = mame_pkg::PH_READ; // RULE15
            next_s.op = instr_valid ? decode(instr) : mame_pkg::OP_NONE;
            next_s.lit = instr[7:0];
            next_s.src = f_res;
            next_s.dst = f_res; // RULE6
            if (next_s.op == mame_pkg::OP_PERIPHERAL_TO_FILE) begin
               next_s.src = p_res; // RULE5
            end
            next_s.rd_addr = next_s.src;
         end
         mame_pkg::PH_READ: begin
            next_s.phase = mame_pkg::PH_PROCESS;
            // working register is a location of its own in this slice
            next_s.opnd = (s.src == mame_pkg::WORK_REG_ADDR) ? s.work_reg
                                                              : rd_data; // RULE7
         end
         mame_pkg::PH_PROCESS: begin
            next_s.phase = mame_pkg::PH_WRITE;
            // external write is raised so it stands through the write phase
            if (s.op == mame_pkg::OP_PERIPHERAL_TO_FILE && !wr_int) begin
               next_s.wr_en = 1'b1; // RULE5
               next_s.wr_addr = s.dst;
               next_s.wr_data = s.opnd;
            end else if (s.op == mame_pkg::OP_WORKING_TO_FILE && !wr_int) begin
               next_s.wr_en = 1'b1; // RULE9
               next_s.wr_addr = s.dst;
               next_s.wr_data = s.work_reg;
            end
         end
         mame_pkg::PH_WRITE: begin
            next_s.phase = mame_pkg::PH_DECODE;
            next_s.decode_phase = 1'b1;
            case (s.op)
               mame_pkg::OP_BANK_HIGH_LOAD: begin
                  next_s.bank_sel = {s.lit[mame_pkg::NIB_LIT_LSB +: 4],
                                     s.bank_sel[3:0]}; // RULE1 RULE2
               end
               mame_pkg::OP_LITERAL_TO_WORKING: begin
                  next_s.work_reg = s.lit; // RULE4
               end
               mame_pkg::OP_PERIPHERAL_TO_FILE: begin
                  next_s.zero = (s.opnd == 8'h00); // RULE5
                  if (wr_int) begin
                     next_s.work_reg = s.opnd; // RULE7
                  end
               end
               mame_pkg::OP_WORKING_TO_FILE: begin
                  // writing the working register onto itself changes nothing
                  next_s.work_reg = s.work_reg; // RULE9
               end
               mame_pkg::OP_LITERAL_MULTIPLY,
               mame_pkg::OP_FILE_MULTIPLY: begin
                  // no flag and no operand is touched here
                  next_s.prod_high = mul.product[15:8]; // RULE12 RULE14
                  next_s.prod_low = mul.product[7:0]; // RULE12 RULE13
               end
               default: begin
                  next_s.op = mame_pkg::OP_NONE;
               end
            endcase
         end
         default: begin
            next_s.phase = mame_pkg::PH_DECODE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s <= RST_S;
      end else begin
         s <= next_s;
      end
   end

   assign decode_phase = s.decode_phase;
   assign rd_addr = s.rd_addr;
   assign wr_en = s.wr_en;
   assign wr_addr = s.wr_addr;
   assign wr_data = s.wr_data;
   assign working_register = s.work_reg;
   assign bank_selection_register = s.bank_sel;
   assign product_high = s.prod_high;
   assign product_low = s.prod_low;
   assign zero_flag = s.zero;
endmodule : mame_exec

// ===== rtl/mame_mul.sv
// unsigned 8x8 multiplier that captures its product on a go cycle
`timescale 1ns/10ps
module mame_mul (
   input wire logic core_clk,
   input wire logic rstn,
   mame_mul_if.unit mul
);
   typedef struct packed {
      logic [15:0] product;
   } mame_mul_s;

   mame_mul_s s;
   mame_mul_s next_s;

   always_comb begin
      next_s = s;
      if (mul.go) begin
         // operands are zero-extended; no carry or overflow can arise
         next_s.product = 16'(mul.a) * 16'(mul.b);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s <= '{product: mame_pkg::PROD_RST};
      end else begin
         s <= next_s;
      end
   end

   assign mul.product = s.product;
endmodule : mame_mul

// ===== rtl/mame_mul_if.sv
// interface: request and product between the executor and the multiplier
`timescale 1ns/10ps
interface mame_mul_if;
   logic go;
   logic [7:0] a;
   logic [7:0] b;
   logic [15:0] product;

   modport requester (
      output go,
      output a,
      output b,
      input product
   );
   modport unit (
      input go,
      input a,
      input b,
      output product
   );
endinterface : mame_mul_if

// ===== rtl/mame_pkg.sv
// package: constants and types of the move and multiply execution slice
package mame_pkg;
   localparam int DATA_W = 8;
   localparam int INSTR_W = 16;
   localparam int PERIPH_W = 5;

   // opcode patterns, compared against the upper instruction bits
   localparam logic [6:0] BANK_HIGH_OP = 7'h5D;
   localparam logic [7:0] LIT_TO_W_OP = 8'hB0;
   localparam logic [2:0] P_TO_F_OP = 3'h2;
   localparam logic [7:0] W_TO_F_OP = 8'h01;
   localparam logic [7:0] LIT_MUL_OP = 8'hBC;
   localparam logic [7:0] FILE_MUL_OP = 8'h34;

   // field positions within the instruction word
   localparam int OP8_LSB = 8;
   localparam int OP7_LSB = 9;
   localparam int OP3_LSB = 13;
   localparam int NIB_LIT_LSB = 4;
   localparam int P_LSB = 8;

   // data space map of the locations handled inside this slice
   localparam logic [7:0] WORK_REG_ADDR = 8'h0A;
   localparam logic [7:0] IND0_ADDR = 8'h00;
   localparam logic [7:0] IND1_ADDR = 8'h08;

   // values after reset
   localparam logic [7:0] WORK_REG_RST = 8'h00;
   localparam logic [7:0] BANK_SEL_RST = 8'h00;
   localparam logic [15:0] PROD_RST = 16'h0000;

   typedef enum logic [1:0] {
      PH_DECODE,
      PH_READ,
      PH_PROCESS,
      PH_WRITE
   } mame_phase_e;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_BANK_HIGH_LOAD,
      OP_LITERAL_TO_WORKING,
      OP_PERIPHERAL_TO_FILE,
      OP_WORKING_TO_FILE,
      OP_LITERAL_MULTIPLY,
      OP_FILE_MULTIPLY
   } mame_op_e;
endpackage : mame_pkg

// ===== verification/mame_exec_checker.sv
// concurrent checks on the ports of the move and multiply slice
`timescale 1ns/10ps
module mame_exec_checker (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   input wire logic [7:0] pointer0,
   input wire logic [7:0] pointer1,
   input wire logic [7:0] rd_data,
   input wire logic decode_phase,
   input wire logic [7:0] rd_addr,
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] working_register,
   input wire logic [7:0] bank_selection_register,
   input wire logic [7:0] product_high,
   input wire logic [7:0] product_low,
   input wire logic zero_flag
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   wire take = decode_phase && instr_valid;
   wire [7:0] op = instr[15:8];
   wire bh = take && instr[15:9] == mame_pkg::BANK_HIGH_OP;
   wire mul = take && (op == mame_pkg::LIT_MUL_OP ||
      op == mame_pkg::FILE_MUL_OP);
   // indirect and working register locations resolve elsewhere
   wire mv = take && instr[15:13] == mame_pkg::P_TO_F_OP &&
      !(instr[12:8] inside {5'h00, 5'h08, 5'h0A});
   wire wf = take && op == mame_pkg::W_TO_F_OP &&
      !(instr[7:0] inside {8'h00, 8'h08, 8'h0A});
   wire fm = take && op == mame_pkg::FILE_MUL_OP &&
      !(instr[7:0] inside {8'h00, 8'h08, 8'h0A});
   AST_PHASE: assert property (
      decode_phase |=> (!decode_phase)[*3] ##1 decode_phase)
      else $error("phase order broken");
   AST_WR_PULSE: assert property (wr_en |=> !wr_en && decode_phase)
      else $error("write outside final phase");
   AST_BANK_HIGH: assert property (
      bh |-> ##4 bank_selection_register[7:4] == $past(instr[7:4], 4))
      else $error("bank high nibble wrong");
   AST_BANK_LOW: assert property (
      bh |-> ##4 bank_selection_register[3:0] ==
         $past(bank_selection_register[3:0], 4))
      else $error("bank low nibble changed");
   AST_LIT_W: assert property (
      take && op == mame_pkg::LIT_TO_W_OP |->
         ##4 working_register == $past(instr[7:0], 4) && $stable(zero_flag))
      else $error("literal load wrong");
   AST_MV_SRC: assert property (
      mv |=> rd_addr == {3'h0, $past(instr[12:8])})
      else $error("move source address wrong");
   AST_MV_ZERO: assert property (
      mv |-> ##4 zero_flag == ($past(rd_data, 3) == 8'h00))
      else $error("move zero flag wrong");
   AST_WF_WRITE: assert property (
      wf |-> ##3 wr_en && wr_addr == $past(instr[7:0], 3) &&
         wr_data == $past(working_register, 3))
      else $error("working register store wrong");
   AST_LIT_MUL: assert property (
      take && op == mame_pkg::LIT_MUL_OP |-> ##4
         {product_high, product_low} ==
         16'($past(instr[7:0], 4)) * 16'($past(working_register, 4)))
      else $error("literal product wrong");
   AST_FILE_MUL: assert property (
      fm |-> ##4 {product_high, product_low} ==
         16'($past(rd_data, 3)) * 16'($past(working_register, 4)))
      else $error("file product wrong");
   AST_MUL_FLAGS: assert property (
      mul |-> ##4 zero_flag == $past(zero_flag, 4) &&
         working_register == $past(working_register, 4))
      else $error("multiply touched flag or register");
   cover property (wf ##3 wr_en);
   cover property (mv ##4 zero_flag);
   cover property (bh);
endmodule : mame_exec_checker

bind mame_exec mame_exec_checker u_chk (.core_clk(core_clk), .rstn(rstn),
   .instr_valid(instr_valid), .instr(instr), .pointer0(pointer0),
   .pointer1(pointer1), .rd_data(rd_data), .decode_phase(decode_phase),
   .rd_addr(rd_addr), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
   .working_register(working_register),
   .bank_selection_register(bank_selection_register),
   .product_high(product_high), .product_low(product_low),
   .zero_flag(zero_flag));

// ===== verification/move_and_multiply_exec_tb_top.sv
// self-checking bench of the move and multiply execution slice
`timescale 1ns/10ps
module move_and_multiply_exec_tb_top;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic instr_valid = 1'b0;
   logic [15:0] instr = 16'h0000;
   logic [7:0] pointer0 = 8'h33;
   logic [7:0] pointer1 = 8'h77;
   logic [7:0] rd_data = 8'h00;
   logic decode_phase, wr_en, zero_flag;
   logic [7:0] rd_addr, wr_addr, wr_data, working_register;
   logic [7:0] bank_selection_register, product_high, product_low;
   logic [7:0] ra, wa, wd;
   logic [15:0] nw;
   int errors = 0;
   int n_tests = 0;

   always #12.5 core_clk = ~core_clk;

   mame_exec dut (.core_clk(core_clk), .rstn(rstn),
      .instr_valid(instr_valid), .instr(instr), .pointer0(pointer0),
      .pointer1(pointer1), .rd_data(rd_data), .decode_phase(decode_phase),
      .rd_addr(rd_addr), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
      .working_register(working_register),
      .bank_selection_register(bank_selection_register),
      .product_high(product_high), .product_low(product_low),
      .zero_flag(zero_flag));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one instruction; returns in the next decode phase
   task automatic exec(input logic [15:0] ins, input logic [7:0] rd);
      int n;
      n = 0;
      while (decode_phase !== 1'b1 && n < 8) begin
         @(negedge core_clk);
         n++;
      end
      instr = ins;
      instr_valid = 1'b1;
      rd_data = rd;
      nw = 16'h0000;
      @(negedge core_clk);
      instr_valid = 1'b0;
      ra = rd_addr;
      repeat (3) begin
         if (wr_en === 1'b1) begin
            nw++;
            wa = wr_addr;
            wd = wr_data;
         end
         @(negedge core_clk);
      end
   endtask : exec

   task automatic t_reset();
      chk(16'(decode_phase), 16'h0001);
      chk({working_register, bank_selection_register}, 16'h0000);
      chk({product_high, product_low}, 16'h0000);
      chk(16'({wr_en, zero_flag}), 16'h0000);
   endtask : t_reset

   // don't-care bits set on purpose
   task automatic t_bank();
      exec(16'hBB5F, 8'hFF);
      chk(16'(bank_selection_register), 16'h0050);
      exec(16'hBA3A, 8'h00);
      chk(16'(bank_selection_register), 16'h0030);
      chk(16'(bank_selection_register[3:0]), 16'h0000);
   endtask : t_bank

   task automatic t_literal();
      exec(16'hB0E2, 8'h00);
      chk({working_register, 7'h00, zero_flag}, 16'hE200);
      exec(16'hBCC4, 8'h00);
      chk({product_high, product_low}, 16'hAD08);
      chk({working_register, nw[7:0]}, 16'hE200);
   endtask : t_literal

   task automatic t_moves();
      exec(16'h4A20, 8'h55);
      chk({ra, wd}, 16'h0AE2);
      chk({nw[7:0], wa}, 16'h0120);
      chk(16'(zero_flag), 16'h0000);
      exec(16'h5FFF, 8'h00);
      chk({ra, wa}, 16'h1FFF);
      chk({wd, 7'h00, zero_flag}, 16'h0001);
      exec(16'h4008, 8'h5A);
      chk({ra, wa}, 16'h3377);
      chk(16'(wd), 16'h005A);
      exec(16'h450A, 8'h3C);
      chk({working_register, nw[7:0]}, 16'h3C00);
      chk(16'(zero_flag), 16'h0000);
   endtask : t_moves

   task automatic t_file_mul();
      exec(16'hBC00, 8'h00);
      chk({product_high, product_low}, 16'h0000);
      chk(16'(zero_flag), 16'h0000);
      exec(16'h5F40, 8'h00);
      exec(16'h3420, 8'hB5);
      chk({product_high, product_low}, 16'h2A6C);
      chk({ra, nw[7:0]}, 16'h2000);
      chk({working_register, 7'h00, zero_flag}, 16'h3C01);
   endtask : t_file_mul

   task automatic t_store();
      exec(16'h01FF, 8'h00);
      chk({nw[7:0], wa}, 16'h01FF);
      chk({wd, 7'h00, zero_flag}, 16'h3C01);
      // unrecognised word must leave everything alone
      exec(16'hFFFF, 8'h00);
      chk({working_register, nw[7:0]}, 16'h3C00);
      chk({product_high, product_low}, 16'h2A6C);
   endtask : t_store

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      #20000;
      errors++;
      report_and_stop();
   end

   initial begin
      repeat (6) @(negedge core_clk);
      t_reset();
      rstn = 1'b1;
      @(negedge core_clk);
      t_bank();
      t_literal();
      t_moves();
      t_file_mul();
      t_store();
      report_and_stop();
   end
endmodule : move_and_multiply_exec_tb_top
